// *** logic/btm_mode_ctrl.sv ***
`timescale 1ns/10ps
module btm_mode_ctrl
	import btm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic mode_select_n,
	input wire logic tx_enable_n,
	input wire logic guardian_enable,
	input wire logic txData,
	input wire logic serialClk,
	input wire logic serial_select_n,
	input wire logic busAboveThresh,
	input wire logic busDiffLow,
	input wire logic wakeEvent,
	input wire logic ioUnderVolt,
	input wire logic coreUnderVolt,
	input wire logic porDetect,
	input wire logic errorFlag,
	input wire logic overTemp,
	input wire logic txTimeout,
	output logic bus_line_pos,
	output logic bus_line_neg,
	output logic busDriveEn_n,
	output logic rxData,
	output logic fault_wake_out_n,
	output logic wakeRxEnable,
	output logic readoutAllowed,
	output logic serialClkInt,
	output logic serialSelectInt_n,
	output logic power_on_flag,
	output logic wakeFlag,
	output logic ioUvFlag,
	output logic coreUvFlag,
	output btm_mode_type mode
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic selS, txenS, geS, txdS, sclkS, scsS, actS, lowS, wakeS, ioS, coreS, porS;
	btm_sync uSel (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(mode_select_n), .sync_out(selS));
	btm_sync uTxen (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(tx_enable_n), .sync_out(txenS));
	btm_sync uGe (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(guardian_enable), .sync_out(geS));
	btm_sync uTxd (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(txData), .sync_out(txdS));
	btm_sync uSclk (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(serialClk), .sync_out(sclkS));
	btm_sync uScs (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(serial_select_n),
		.sync_out(scsS));
	btm_sync uAct (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(busAboveThresh),
		.sync_out(actS));
	btm_sync uLow (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(busDiffLow), .sync_out(lowS));
	btm_sync uWake (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(wakeEvent), .sync_out(wakeS));
	btm_sync uIo (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(ioUnderVolt), .sync_out(ioS));
	btm_sync uCore (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(coreUnderVolt),
		.sync_out(coreS));
	btm_sync uPor (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(porDetect), .sync_out(porS));

	// ----------------------------------------
	// internal input copies
	// ----------------------------------------
	// io undervoltage forces safe levels on all controller inputs
	wire selInt = ioS ? 1'b0 : selS; // [R17]
	wire geInt = ioS ? 1'b0 : geS; // [R17]
	wire txdInt = ioS ? 1'b0 : txdS; // [R17]
	wire txenInt_n = ioS ? 1'b1 : txenS; // [R17] [R2]
	wire sclkInt = ioS ? 1'b1 : sclkS; // [R17]
	wire scsInt_n = ioS ? 1'b1 : scsS; // [R17]

	// ----------------------------------------
	// mode machine
	// ----------------------------------------
	btm_mode_type next_mode;
	wire normalOk = selInt && !ioUvFlag && !coreUvFlag;
	wire isNormal = (mode == MODE_NORMAL);
	wire isStandby = (mode == MODE_STANDBY);
	always_comb begin
		next_mode = mode;
		unique case (mode)
			MODE_OFF: begin
				if (!porS) next_mode = MODE_STANDBY; // [R21]
			end
			MODE_STANDBY: begin
				if (porS) next_mode = MODE_OFF; // [R21]
				else if (normalOk) next_mode = MODE_NORMAL; // [R23] [R1]
			end
			MODE_NORMAL: begin
				if (porS) next_mode = MODE_OFF; // [R21]
				else if (!normalOk) next_mode = MODE_STANDBY; // [R22] [R1]
			end
			default: next_mode = MODE_OFF;
		endcase
	end

	// ----------------------------------------
	// flags
	// ----------------------------------------
	wire enterNormal = isStandby && (next_mode == MODE_NORMAL);
	wire leaveOff = (mode == MODE_OFF) && (next_mode == MODE_STANDBY);
	wire offNext = (next_mode == MODE_OFF);
	// wake receiver runs only in Standby without core undervoltage,
	// and is dropped on the way into Power-off so nothing lingers there
	wire wakeRxOn = isStandby && !coreUvFlag && !offNext; // [R12] [R13] [R20]
	logic clearPwonPending;
	logic heldWake;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode <= MODE_OFF;
			wakeFlag <= 1'b0;
			power_on_flag <= 1'b0;
			clearPwonPending <= 1'b0;
			ioUvFlag <= 1'b1;
			coreUvFlag <= 1'b1;
			heldWake <= 1'b0;
		end else begin
			mode <= next_mode;
			// flags start set and track supplies once out of Power-off
			ioUvFlag <= (mode == MODE_OFF) ? 1'b1 : ioS;
			coreUvFlag <= (mode == MODE_OFF || porS) ? 1'b1 : coreS; // [R24]
			// wake flag cleared first, power-on flag one cycle later
			if (wakeRxOn && wakeS) wakeFlag <= 1'b1; // [R15]
			else if (enterNormal || offNext) wakeFlag <= 1'b0; // [R23] [R20]
			if (leaveOff) power_on_flag <= 1'b1; // [R24]
			else if (clearPwonPending) power_on_flag <= 1'b0; // [R23]
			clearPwonPending <= enterNormal;
			if (!coreUvFlag) heldWake <= wakeFlag; // [R16]
		end
	end

	// ----------------------------------------
	// transmitter
	// ----------------------------------------
	// guardian ignored outside Normal, so Standby cannot enable it
	wire txGate = isNormal && geInt && !txenInt_n && !overTemp && !txTimeout; // [R3] [R4] [R19]
	logic txActive;
	btm_rx_if rxi ();
	assign rxi.sample = actS;
	assign rxi.enable = isNormal; // [R3]
	btm_activity uAct0 (.ref_clk(ref_clk), .reset_n(reset_n), .aboveThresh(actS),
		.diffLow(lowS), .rx(rxi));

	wire stbyOut = coreUvFlag ? heldWake : wakeFlag; // [R16]
	wire rxNext = isNormal ? !rxi.dataLow : (isStandby ? !stbyOut : 1'b1); // [R8] [R14] [R20]
	wire errNext = isNormal ? !errorFlag : (isStandby ? (ioUvFlag ? 1'b0 : !stbyOut) : 1'b1); // [R9] [R14]
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			txActive <= 1'b0;
			bus_line_pos <= 1'b0;
			bus_line_neg <= 1'b0;
			busDriveEn_n <= 1'b1;
			rxData <= 1'b1;
			fault_wake_out_n <= 1'b1;
			wakeRxEnable <= 1'b0;
			readoutAllowed <= 1'b0;
			serialClkInt <= 1'b1;
			serialSelectInt_n <= 1'b1;
		end else begin
			// activation waits for the first low data while gated on
			if (!txGate) txActive <= 1'b0; // [R4]
			else if (!txdInt) txActive <= 1'b1; // [R7]
			bus_line_pos <= txGate && txActive && txdInt; // [R5] [R6]
			bus_line_neg <= txGate && txActive && !txdInt; // [R5] [R6]
			busDriveEn_n <= !(txGate && (txActive || !txdInt)); // [R7]
			rxData <= ioUvFlag ? 1'b0 : rxNext;
			fault_wake_out_n <= errNext;
			wakeRxEnable <= wakeRxOn; // [R12]
			// io undervoltage in Normal forces Standby anyway, so refuse at once
			readoutAllowed <= !offNext && (mode != MODE_OFF) && !ioUvFlag; // [R18] [R20]
			serialClkInt <= sclkInt;
			serialSelectInt_n <= scsInt_n;
		end
	end
endmodule

// *** inc/btm_pkg.sv ***
// Functional notes
// R1 - mode select high Normal, low Standby
// R2 - tx enable active low, high disables transmitter
// R3 - Normal enables transmitter, receiver, undervoltage detect
// R4 - guardian low or tx_enable_n high keeps idle
// R5 - data high drives DATA_1, pos high
// R6 - data low drives DATA_0, neg high
// R7 - transmitter activates at first low data
// R8 - Normal routes receiver to receive data
// R9 - Normal error output shows error flag
// R10 - activity after threshold held for activity time
// R11 - idle after below threshold for idle time
// R12 - Standby: wake receiver only without core undervoltage
// R13 - core undervoltage blocks wake flag setting
// R14 - Standby outputs show wake flag, low set
// R15 - Standby valid wake event sets wake flag
// R16 - core undervoltage holds prior wake value
// R17 - io undervoltage forces internal input copies
// R18 - io undervoltage in Standby refuses readout
// R19 - guardian enable ignored in Standby
// R20 - Power-off: all off, no wake, no readout
// R21 - reset release enters Standby; reassert Power-off
// R22 - Normal to Standby on select low or undervoltage
// R23 - Standby to Normal clears wake then power-on
// R24 - power-on flag set entering Standby
// R25 - controller transmits only in valid Normal mode
package btm_pkg;
	localparam int CLK_MHZ = 200;
	// activity and idle qualification times in ns
	localparam int ACT_TIME_NS = 100;
	localparam int IDLE_TIME_NS = 100;
	localparam int ACT_CYCLES = (ACT_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int IDLE_CYCLES = (IDLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 8;
	typedef enum logic [2:0] {
		MODE_OFF = 3'b001,
		MODE_STANDBY = 3'b010,
		MODE_NORMAL = 3'b100
	} btm_mode_type;
endpackage

// *** inc/btm_rx_if.sv ***
`timescale 1ns/10ps
interface btm_rx_if;
	logic sample;
	logic enable;
	logic active;
	logic dataLow;
	modport ctrl (output sample, output enable, input active, input dataLow);
	modport det (input sample, input enable, output active, output dataLow);
endinterface

// *** logic/btm_sync.sv ***
`timescale 1ns/10ps
module btm_sync (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// *** logic/btm_activity.sv ***
`timescale 1ns/10ps
module btm_activity
	import btm_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic aboveThresh,
	input wire logic diffLow,
	btm_rx_if.det rx
);
	logic [CNT_W-1:0] count;
	wire activeHit = aboveThresh && (count >= CNT_W'(ACT_CYCLES - 1));
	wire idleHit = !aboveThresh && (count >= CNT_W'(IDLE_CYCLES - 1));
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= '0;
			rx.active <= 1'b0;
			rx.dataLow <= 1'b0;
		end else if (!rx.enable) begin
			count <= '0;
			rx.active <= 1'b0;
			rx.dataLow <= 1'b0;
		end else begin
			// count only while the level disagrees with the declared state
			if (aboveThresh == rx.active) begin
				count <= '0;
			end else if (!rx.active && activeHit) begin
				rx.active <= 1'b1; // [R10]
				count <= '0;
			end else if (rx.active && idleHit) begin
				rx.active <= 1'b0; // [R11]
				count <= '0;
			end else begin
				count <= count + CNT_W'(1);
			end
			rx.dataLow <= rx.active && aboveThresh && diffLow; // [R10]
		end
	end
endmodule

// *** sim/btm_ctrl_model.sv ***
`timescale 1ns/10ps
module btm_ctrl_model (
	input wire logic ref_clk,
	input wire logic wantNormal,
	input wire logic [2:0] txCmd,
	output logic mode_select_n,
	output logic guardian_enable,
	output logic tx_enable_n,
	output logic txData
);
	// pins move after the falling edge, clear of the sampling edge
	always @(negedge ref_clk) begin
		mode_select_n <= wantNormal;
		{guardian_enable, tx_enable_n, txData} <= txCmd;
	end
endmodule

// *** sim/btm_mode_ctrl_properties.sv ***
`timescale 1ns/10ps
module btm_mode_props (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic bus_line_pos,
	input wire logic bus_line_neg,
	input wire logic busDriveEn_n,
	input wire logic rxData,
	input wire logic fault_wake_out_n,
	input wire logic wakeRxEnable,
	input wire logic readoutAllowed,
	input wire logic power_on_flag,
	input wire logic wakeFlag,
	input wire logic ioUvFlag,
	input wire logic coreUvFlag,
	input btm_pkg::btm_mode_type mode
);
	import btm_pkg::*;
	wire isNorm = mode == MODE_NORMAL;
	wire stbyOk = mode == MODE_STANDBY && !ioUvFlag && !coreUvFlag;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	a_drive_opposite: assert property (!$past(busDriveEn_n) && !busDriveEn_n
		|-> bus_line_pos != bus_line_neg) else $error("bus lines equal while driving");
	a_drive_normal: assert property (!isNorm && !$past(isNorm) |-> busDriveEn_n)
		else $error("driving outside normal");
	a_off_quiet: assert property (mode == MODE_OFF
		|-> !wakeFlag && !readoutAllowed && !wakeRxEnable) else $error("power-off not quiet");
	a_normal_entry: assert property ($rose(isNorm) |-> !wakeFlag ##1 !power_on_flag)
		else $error("flags not cleared on normal entry");
	a_pof_entry: assert property ($past(mode) == MODE_OFF && mode == MODE_STANDBY
		|-> power_on_flag) else $error("power-on flag not set");
	a_core_uv_rx: assert property ($past(coreUvFlag) && coreUvFlag |-> !wakeRxEnable)
		else $error("wake receiver on in core undervoltage");
	a_io_uv_read: assert property ($past(ioUvFlag) && ioUvFlag && mode == MODE_STANDBY
		|-> !readoutAllowed) else $error("readout allowed in io undervoltage");
	a_stby_wake_out: assert property (stbyOk && $past(stbyOk) && $stable(wakeFlag)
		|-> rxData == !wakeFlag && fault_wake_out_n == !wakeFlag) else $error("standby outputs");
	c_normal: cover property ($rose(isNorm));
	c_wake: cover property ($rose(wakeFlag));
	c_drive: cover property ($fell(busDriveEn_n));
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	import btm_pkg::*;
	logic ref_clk = 1'h0;
	logic reset_n = 1'h0;
	logic wantNormal = 1'h0;
	logic [2:0] txCmd = 3'h2;
	logic serialClk = 1'h0, serial_select_n = 1'h0, busAboveThresh = 1'h0, busDiffLow = 1'h0;
	logic wakeEvent = 1'h0, ioUnderVolt = 1'h0, coreUnderVolt = 1'h0, porDetect = 1'h0;
	logic errorFlag = 1'h0, overTemp = 1'h0, txTimeout = 1'h0;
	logic mode_select_n, tx_enable_n, guardian_enable, txData, bus_line_pos, bus_line_neg;
	logic busDriveEn_n, rxData, fault_wake_out_n, wakeRxEnable, readoutAllowed, serialClkInt;
	logic serialSelectInt_n, power_on_flag, wakeFlag, ioUvFlag, coreUvFlag;
	btm_mode_type mode;
	int fail_count = 0, tests_run = 0;
	// {guard, tx_enable_n, txd, above, diffLow, err} then {drvEn_n, pos, neg, rx, fault_n}
	logic [10:0] rows [9] = '{11'h513, 11'h407, 11'h50B, 11'h113, 11'h613, 11'h513,
		11'h2D1, 11'h2B2, 11'h213};
	always #2.5 ref_clk = ~ref_clk;
	btm_ctrl_model btm_ctrl_model_inst (.*);
	btm_mode_ctrl btm_mode_ctrl_inst (.*);
	task automatic check(input logic [4:0] seen, input logic [4:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic waitMode(input btm_mode_type m);
		repeat (300) if (mode !== m) @(negedge ref_clk);
		check(mode, m, "mode");
		if (mode !== m) tally_and_finish();
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic pulseWake;
		settle(8);
		wakeEvent = 1'h1;
		settle(4);
		wakeEvent = 1'h0;
		settle(8);
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	initial begin
		settle(4);
		reset_n = 1'h1;
		waitMode(MODE_STANDBY);
		check(power_on_flag, 1'h1, "powerOn");
		wantNormal = 1'h1;
		waitMode(MODE_NORMAL);
		settle(1);
		check({wakeFlag, power_on_flag}, 2'h0, "entryFlags");
		// activity qualification is slow, so each row waits past it
		foreach (rows[i]) begin
			{txCmd, busAboveThresh, busDiffLow, errorFlag} = rows[i][10:5];
			settle(ACT_CYCLES + 10);
			check({busDriveEn_n, busDriveEn_n ? 2'h0 : {bus_line_pos, bus_line_neg}, rxData,
				fault_wake_out_n}, rows[i][4:0], "row");
		end
		txCmd = 3'h4;
		settle(8);
		wantNormal = 1'h0;
		waitMode(MODE_STANDBY);
		settle(8);
		check({busDriveEn_n, wakeFlag, rxData, fault_wake_out_n}, 4'hB, "standby");
		coreUnderVolt = 1'h1;
		pulseWake();
		check({wakeRxEnable, wakeFlag}, 2'h0, "coreUvWake");
		coreUnderVolt = 1'h0;
		pulseWake();
		check({wakeFlag, rxData, fault_wake_out_n}, 3'h4, "wake");
		coreUnderVolt = 1'h1;
		settle(8);
		check({rxData, fault_wake_out_n}, 2'h0, "uvHold");
		coreUnderVolt = 1'h0;
		ioUnderVolt = 1'h1;
		settle(8);
		check({readoutAllowed, serialClkInt, serialSelectInt_n}, 3'h3, "ioUv");
		ioUnderVolt = 1'h0;
		settle(4);
		check({serialClkInt, serialSelectInt_n}, 2'h0, "serialEcho");
		wantNormal = 1'h1;
		waitMode(MODE_NORMAL);
		check(wakeFlag, 1'h0, "wakeCleared");
		settle(6);
		check(busDriveEn_n, 1'h0, "txOn");
		overTemp = 1'h1;
		settle(2);
		check(busDriveEn_n, 1'h1, "overTemp");
		overTemp = 1'h0;
		txTimeout = 1'h1;
		settle(2);
		check(busDriveEn_n, 1'h1, "txTimeout");
		txTimeout = 1'h0;
		settle(4);
		check(busDriveEn_n, 1'h0, "txAgain");
		ioUnderVolt = 1'h1;
		waitMode(MODE_STANDBY);
		ioUnderVolt = 1'h0;
		wantNormal = 1'h0;
		porDetect = 1'h1;
		waitMode(MODE_OFF);
		check({busDriveEn_n, wakeRxEnable, readoutAllowed}, 3'h4, "off");
		porDetect = 1'h0;
		waitMode(MODE_STANDBY);
		check(power_on_flag, 1'h1, "powerOnAgain");
		// mid-run reset returns the digital section to Power-off
		reset_n = 1'h0;
		settle(2);
		check({mode, busDriveEn_n, rxData}, {MODE_OFF, 2'h3}, "resetOut");
		reset_n = 1'h1;
		waitMode(MODE_STANDBY);
		check(power_on_flag, 1'h1, "powerOnReset");
		tally_and_finish();
	end
endmodule
bind btm_mode_ctrl btm_mode_props btm_mode_props_inst (.*);
